//--- pkg/dmrc_map.svh
`ifndef DMRC_MAP_SVH
`define DMRC_MAP_SVH
`define DMRC_ADDR_W      9
`define DMRC_STROBES     4
`define DMRC_CNT_ZERO    9'h000
`define DMRC_CNT_ONE     9'h001
`define DMRC_ALL_OFF     4'hf
`define DMRC_ALL_ON      4'h0
`define DMRC_MODE_EXT_RF 2'h0
`define DMRC_MODE_AUT_RF 2'h1
`define DMRC_MODE_EXT_AC 2'h2
`define DMRC_MODE_AUT_AC 2'h3
// row hold delay in core_clk cycles: short and long settings
`define DMRC_HOLD_SHORT  4'h1
`define DMRC_HOLD_LONG   4'h2
`define DMRC_HOLD_ZERO   4'h0
`endif

//--- pkg/dmrc_pkg.sv
package dmrc_pkg;
    typedef enum logic [1:0] {
        DMRC_EXT_REFRESH,
        DMRC_AUTO_REFRESH,
        DMRC_EXT_ACCESS,
        DMRC_AUTO_ACCESS
    } dmrc_mode_type;

    typedef struct packed {
        logic [8:0] row;
        logic [8:0] col;
        logic       bank_select_low;
        logic       bank_select_high;
    } dmrc_addr_type;

    typedef struct packed {
        logic [3:0] row_strobe_n;
        logic       col_strobe_n;
        logic       write_en_n;
        logic [8:0] muxed_address_out;
    } dmrc_dram_type;
endpackage : dmrc_pkg

//--- verif/dmrc_controller_assertions.sv
`timescale 1ns/1ps
// ****
// port checks, base variant
// ****
module dmrc_controller_chk
(
    input wire logic                    core_clk,
    input wire logic                    rst,
    input wire logic [8:0]              row_addr_in,
    input wire logic                    bank_select_low,
    input wire logic                    bank_select_high,
    input wire logic                    address_latch_strobe,
    input wire logic                    chip_select_n,
    input wire logic                    mode_select_a,
    input wire logic                    mode_select_b,
    input wire logic                    row_strobe_in_n,
    input wire logic                    row_col_select,
    input wire logic                    refresh_request_pin_i,
    input wire logic                    refresh_request_pin_oe,
    input wire dmrc_pkg::dmrc_dram_type dram_out,
    input wire logic                    dram_out_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire rfs = !mode_select_b && !row_strobe_in_n;
    wire acc = mode_select_b && !mode_select_a && !chip_select_n && !row_strobe_in_n && address_latch_strobe;
    refresh_all_a: assert property (rfs |=> dram_out.row_strobe_n == 4'h0 && dram_out.col_strobe_n)
        else $error("refresh strobes wrong");
    bank_decode_a: assert property (acc |=> dram_out.row_strobe_n == ~(4'h1 << $past({bank_select_high, bank_select_low})))
        else $error("bank decode wrong");
    row_address_a: assert property (acc && row_col_select |=> dram_out.muxed_address_out == $past(row_addr_in))
        else $error("row address wrong");
    deselect_block_a: assert property (mode_select_b && !mode_select_a && chip_select_n |=> dram_out.row_strobe_n == 4'hf)
        else $error("access while deselected");
    never_float_a: assert property (dram_out_oe)
        else $error("outputs released");
    refresh_steady_a: assert property (rfs [*2] |=> $stable(dram_out.muxed_address_out))
        else $error("refresh address moved");
    mode0_quiet_a: assert property (!mode_select_b && !mode_select_a && !refresh_request_pin_oe |=> !refresh_request_pin_oe)
        else $error("request raised in mode 0");
    counter_clear_a: assert property (!refresh_request_pin_i && !refresh_request_pin_oe && row_strobe_in_n
        && $past(row_strobe_in_n) ##1 rfs |=> dram_out.muxed_address_out == 9'h000) else $error("counter not cleared");
endmodule : dmrc_controller_chk
bind dmrc_controller dmrc_controller_chk chk (.core_clk, .rst, .row_addr_in, .bank_select_low, .bank_select_high,
    .address_latch_strobe, .chip_select_n, .mode_select_a, .mode_select_b, .row_strobe_in_n, .row_col_select,
    .refresh_request_pin_i, .refresh_request_pin_oe, .dram_out, .dram_out_oe);

//--- verif/dmrc_pin_model.sv
`timescale 1ns/1ps
// ****
// refresh request wire, pulled up
// ****
module dmrc_pin_model
(
    input  wire logic ext_pull_low,
    input  wire logic refresh_request_pin_oe,
    output      logic refresh_request_pin_i
);
    // outside gate may pull low to clear the counter
    assign refresh_request_pin_i = (ext_pull_low || refresh_request_pin_oe) ? 1'b0 : 1'b1;
endmodule : dmrc_pin_model

//--- verif/test_dram_address_mux_refresh_controller.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
    $display("Error %s expected %h seen %h", n, e, a); end end
module test_dram_address_mux_refresh_controller;
    logic [8:0] row_addr_in = 9'h000, col_addr_in = 9'h000;
    logic core_clk = 1'b0, rst = 1'b1, bank_select_low = 1'b0, bank_select_high = 1'b0, write_en_in_n = 1'b1;
    logic address_latch_strobe = 1'b1, chip_select_n = 1'b1, mode_select_a = 1'b0, mode_select_b = 1'b0;
    logic row_strobe_in_n = 1'b1, column_strobe_in_n = 1'b1, row_col_select = 1'b1, row_hold_select = 1'b0;
    logic ext_pull_low = 1'b0, refresh_request_pin_i, refresh_request_pin_o, refresh_request_pin_oe, dram_out_oe;
    dmrc_pkg::dmrc_dram_type dram_out;
    int miscompares = 0, total_checks = 0, cycles = 0;
    // bank, row, column, expected row strobes
    logic [23:0] rows [4] = '{{2'h0, 9'h1ff, 9'h000, 4'he}, {2'h1, 9'h000, 9'h1ff, 4'hd},
                              {2'h2, 9'h155, 9'h0aa, 4'hb}, {2'h3, 9'h0aa, 9'h155, 4'h7}};
    dmrc_controller uut (.row_addr_in, .col_addr_in, .bank_select_low, .bank_select_high, .core_clk, .rst,
        .address_latch_strobe, .chip_select_n, .mode_select_a, .mode_select_b, .row_strobe_in_n, .column_strobe_in_n,
        .row_col_select, .write_en_in_n, .row_hold_select, .refresh_request_pin_i, .refresh_request_pin_o,
        .refresh_request_pin_oe, .dram_out, .dram_out_oe);
    dmrc_pin_model pin (.ext_pull_low, .refresh_request_pin_oe, .refresh_request_pin_i);
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    task automatic refresh_once(input logic [8:0] expect_addr);
        @(negedge core_clk);
        row_strobe_in_n = 1'b0;
        @(negedge core_clk);
        `CHK("refresh strobes", 4'h0, dram_out.row_strobe_n)
        `CHK("refresh column strobe", 1'b1, dram_out.col_strobe_n)
        `CHK("refresh address", expect_addr, dram_out.muxed_address_out)
        row_strobe_in_n = 1'b1;
        repeat (2) @(negedge core_clk);
    endtask : refresh_once
    initial
    begin
        repeat (3) @(negedge core_clk);
        `CHK("reset outputs", 15'h7e00, dram_out)
        `CHK("reset request", 1'b0, refresh_request_pin_oe)
        rst = 1'b0;
        {mode_select_b, chip_select_n} = 2'h2;
        foreach (rows[i])
        begin
            @(negedge core_clk);
            {bank_select_high, bank_select_low, row_addr_in, col_addr_in} = rows[i][23:4];
            @(negedge core_clk);
            row_strobe_in_n = 1'b0;
            @(negedge core_clk);
            `CHK("row strobes", rows[i][3:0], dram_out.row_strobe_n)
            `CHK("row address", rows[i][21:13], dram_out.muxed_address_out)
            row_col_select = 1'b0;
            @(negedge core_clk);
            `CHK("column address", rows[i][12:4], dram_out.muxed_address_out)
            column_strobe_in_n = 1'b0;
            @(negedge core_clk);
            `CHK("column strobe", 1'b0, dram_out.col_strobe_n)
            {row_strobe_in_n, column_strobe_in_n, row_col_select} = 3'h7;
            @(negedge core_clk);
            `CHK("idle strobes", 4'hf, dram_out.row_strobe_n)
        end
        // auto access: column strobe waits out the chosen row hold
        mode_select_a = 1'b1;
        for (int h = 0; h < 2; h++)
        begin
            row_hold_select = h[0];
            @(negedge core_clk);
            row_strobe_in_n = 1'b0;
            repeat (h + 1) @(negedge core_clk);
            `CHK("held row address", 9'h0aa, dram_out.muxed_address_out)
            `CHK("held column strobe", 1'b1, dram_out.col_strobe_n)
            @(negedge core_clk);
            `CHK("auto column address", 9'h155, dram_out.muxed_address_out)
            `CHK("auto column strobe", 1'b0, dram_out.col_strobe_n)
            row_strobe_in_n = 1'b1;
        end
        mode_select_a = 1'b0;
        // deselected access must be refused, outputs still driven high
        chip_select_n = 1'b1;
        row_strobe_in_n = 1'b0;
        repeat (2) @(negedge core_clk);
        `CHK("deselected strobes", 4'hf, dram_out.row_strobe_n)
        `CHK("output enable", 1'b1, dram_out_oe)
        row_strobe_in_n = 1'b1;
        mode_select_b = 1'b0;
        // refresh runs with chip select still high
        refresh_once(9'h000);
        refresh_once(9'h001);
        @(negedge core_clk);
        ext_pull_low = 1'b1;
        @(negedge core_clk);
        ext_pull_low = 1'b0;
        refresh_once(9'h000);
        for (int k = 1; k < 512; k++)
            refresh_once(k[8:0]);
        refresh_once(9'h000);
        // reset in mid-run must restore idle outputs and a zero counter
        rst = 1'b1;
        @(negedge core_clk);
        `CHK("mid-run reset outputs", 15'h7e00, dram_out)
        rst = 1'b0;
        refresh_once(9'h000);
        `CHK("mode 0 request", 1'b0, refresh_request_pin_oe)
        `CHK("request drive level", 1'b0, refresh_request_pin_o)
        report_and_stop();
    end
endmodule : test_dram_address_mux_refresh_controller

//--- verilog/dmrc_addr_latch.sv
`timescale 1ns/1ps
`include "dmrc_map.svh"
module dmrc_addr_latch
(
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic                   address_latch_strobe,
    input  wire dmrc_pkg::dmrc_addr_type addr_in,
    output      dmrc_pkg::dmrc_addr_type addr_out
);
    dmrc_pkg::dmrc_addr_type hold_q;

    // capture each cycle while strobe high, freeze once it falls
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            hold_q <= '0;
        else if (address_latch_strobe)
            hold_q <= addr_in;
    end

    // fall-through while strobe high, held copy otherwise
    assign addr_out = address_latch_strobe ? addr_in : hold_q;
endmodule : dmrc_addr_latch

//--- verilog/dmrc_controller.sv
`timescale 1ns/1ps
`include "dmrc_map.svh"
// What this block does
// - refresh drives counter out, increments after
// - latches transparent or capturing as host needs
// - four row strobes, nine address outputs
// - base variant: bank selects decode to one strobe
// - two mode pins: refresh/access, external/automatic
// - only modes 0, 1, 4, 5 exist
// - float variant releases outputs when deselected idle
// - base variant holds row and column strobes high when deselected idle
// - wide variant: high select picks strobe pair
// - wide variant never does hidden refresh
// - row hold select picks hold in mode 5
// - mode 0 refresh pin gives no end-of-count
// - refresh pin pulled low clears counter
// - refresh: all row strobes, column strobe high
// - base decode 00..11 to strobes zero..three
// - latches follow strobe high, capture on fall
module dmrc_controller
#(
    parameter bit FLOAT_VARIANT = 1'b0,
    parameter bit WIDE_VARIANT  = 1'b0
)
(
    input  wire logic [8:0]           row_addr_in,
    input  wire logic [8:0]           col_addr_in,
    input  wire logic                 bank_select_low,
    input  wire logic                 bank_select_high,
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 address_latch_strobe,
    input  wire logic                 chip_select_n,
    input  wire logic                 mode_select_a,
    input  wire logic                 mode_select_b,
    input  wire logic                 row_strobe_in_n,
    input  wire logic                 column_strobe_in_n,
    input  wire logic                 row_col_select,
    input  wire logic                 write_en_in_n,
    input  wire logic                 row_hold_select,
    input  wire logic                 refresh_request_pin_i,
    output      logic                 refresh_request_pin_o,
    output      logic                 refresh_request_pin_oe,
    output      dmrc_pkg::dmrc_dram_type dram_out,
    output      logic                 dram_out_oe
);
    // ************************************************************
    // address latch
    // ************************************************************
    dmrc_pkg::dmrc_addr_type addr_in;
    dmrc_pkg::dmrc_addr_type addr_lat;

    assign addr_in = '{row: row_addr_in, col: col_addr_in,
                       bank_select_low: bank_select_low, bank_select_high: bank_select_high};

    dmrc_addr_latch u_latch
    (
        .core_clk             (core_clk),
        .rst                  (rst),
        .address_latch_strobe (address_latch_strobe),
        .addr_in              (addr_in),
        .addr_out             (addr_lat)
    );

    // ************************************************************
    // mode and bank decode
    // ************************************************************
    // two pins reach only modes 0, 1, 4, 5; the others cannot be encoded
    dmrc_pkg::dmrc_mode_type mode;
    assign mode = dmrc_pkg::dmrc_mode_type'({mode_select_b, mode_select_a});

    function automatic logic [3:0] bank_decode(input logic hi, input logic lo, input bit wide);
        logic [3:0] sel;
        sel = `DMRC_ALL_OFF;
        if (wide)
            sel = hi ? 4'h3 : 4'hc;
        else
            sel[{hi, lo}] = 1'b0;
        return sel;
    endfunction : bank_decode

    wire        is_refresh_mode = (mode == dmrc_pkg::DMRC_EXT_REFRESH) || (mode == dmrc_pkg::DMRC_AUTO_REFRESH);
    wire        is_auto_access  = (mode == dmrc_pkg::DMRC_AUTO_ACCESS);
    wire        selected        = !chip_select_n;
    wire [3:0]  bank_sel_n      = bank_decode(addr_lat.bank_select_high, addr_lat.bank_select_low, WIDE_VARIANT);

    // ************************************************************
    // refresh counter and auto-refresh request
    // ************************************************************
    logic [8:0] cnt_q;
    logic       row_in_q;
    logic       refreshing_q;
    logic       req_q;
    logic       refresh_clock_in_q;
    logic       hidden_done_q;

    // in auto modes row_col_select is the refresh clock
    wire refresh_clock_in_rise = row_col_select && !refresh_clock_in_q;
    wire refresh_clock_in_fall = !row_col_select && refresh_clock_in_q;
    // hidden_ok: deselected idle cycle in auto access, not in wide variant; refresh_now also needs row_strobe_in_n low, so it never fires
    wire hidden_ok = !WIDE_VARIANT && is_auto_access && chip_select_n && row_col_select
                     && !hidden_done_q && row_strobe_in_n;
    wire refresh_now = (is_refresh_mode && !row_strobe_in_n) || (hidden_ok && !row_strobe_in_n);
    wire refresh_end = refreshing_q && row_strobe_in_n;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q         <= `DMRC_CNT_ZERO;
            row_in_q      <= 1'b1;
            refreshing_q  <= 1'b0;
            refresh_clock_in_q        <= 1'b0;
            hidden_done_q <= 1'b0;
            req_q         <= 1'b0;
        end
        else
        begin
            row_in_q     <= row_strobe_in_n;
            refresh_clock_in_q       <= row_col_select;
            refreshing_q <= refresh_now || (refreshing_q && !row_strobe_in_n);
            if (!refresh_request_pin_i && !req_q)
                cnt_q <= `DMRC_CNT_ZERO;
            else if (refresh_end)
                cnt_q <= cnt_q + `DMRC_CNT_ONE;
            if (refresh_clock_in_rise)
                hidden_done_q <= 1'b0;
            else if (refresh_end)
                hidden_done_q <= 1'b1;
            // request only in auto modes; mode 0 leaves the pin released
            if (mode == dmrc_pkg::DMRC_EXT_REFRESH)
                req_q <= 1'b0;
            else if (refresh_clock_in_fall && !hidden_done_q && mode != dmrc_pkg::DMRC_EXT_ACCESS)
                req_q <= 1'b1;
            else if (refresh_end)
                req_q <= 1'b0;
        end
    end

    // ************************************************************
    // dram outputs
    // ************************************************************
    logic [3:0] hold_cnt_q;
    wire        access_on  = selected && !is_refresh_mode && !row_strobe_in_n;
    wire        any_refresh = refresh_now || refreshing_q;
    // auto mode: column strobe waits out the selected row hold
    wire [3:0]  hold_target = row_hold_select ? `DMRC_HOLD_LONG : `DMRC_HOLD_SHORT;
    wire        hold_done   = (hold_cnt_q >= hold_target);
    wire        show_col    = is_auto_access ? hold_done : !row_col_select;
    wire        col_n_next  = any_refresh ? 1'b1 :
                              !access_on ? 1'b1 :
                              is_auto_access ? !hold_done :
                              (column_strobe_in_n || row_col_select);
    wire [3:0]  strobes_next = any_refresh ? (row_strobe_in_n ? `DMRC_ALL_OFF : `DMRC_ALL_ON) :
                               access_on ? bank_sel_n : `DMRC_ALL_OFF;
    wire [8:0]  addr_next   = any_refresh ? cnt_q :
                              show_col ? addr_lat.col : addr_lat.row;
    wire        idle_desel  = chip_select_n && !any_refresh;
    dmrc_pkg::dmrc_dram_type dram_d;

    assign dram_d = '{row_strobe_n: idle_desel ? `DMRC_ALL_OFF : strobes_next,
                      col_strobe_n: idle_desel ? 1'b1 : col_n_next,
                      write_en_n: write_en_in_n,
                      muxed_address_out: addr_next};

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            hold_cnt_q             <= `DMRC_HOLD_ZERO;
            dram_out               <= '{row_strobe_n: `DMRC_ALL_OFF, col_strobe_n: 1'b1,
                                        write_en_n: 1'b1, muxed_address_out: `DMRC_CNT_ZERO};
            dram_out_oe            <= 1'b1;
            refresh_request_pin_o  <= 1'b0;
            refresh_request_pin_oe <= 1'b0;
        end
        else
        begin
            if (!access_on || !is_auto_access)
                hold_cnt_q <= `DMRC_HOLD_ZERO;
            else if (!hold_done)
                hold_cnt_q <= hold_cnt_q + 4'h1;
            dram_out               <= dram_d;
            dram_out_oe            <= FLOAT_VARIANT ? !idle_desel : 1'b1;
            // open-drain request: drive low while pending
            refresh_request_pin_o  <= 1'b0;
            refresh_request_pin_oe <= req_q;
        end
    end
endmodule : dmrc_controller
